// file: design/ready_summary_pkg.sv
// Constants shared by the FIFO-ready summary block and its per-channel cell.
// Assumes a single 40 MHz reference clock and a receive clock made by enable pulses.
//
// Overview of operation
// [R1] Summary bits 0-3 are tx-ready, channels A-D
// [R2] Mode 0 tx-ready: 1 only when FIFO empty
// [R3] Mode 1 tx-ready: 0 when full, else 1
// [R4] Bits 4-7 rx-ready; mode 0: FIFO not empty
// [R5] Mode 1 rx-ready: trigger reached or time-out
// [R6] Receive interrupt within one rclk of stop
// [R7] Transmit starts 8-24 rclk after first clear
// [R8] Rx-ready raised within one rclk of stop
// [R9] Tx-ready dropped within 8 rclk of start
// [R10] Host selects register by select pin low
// [R11] Summary reads zero right after reset
// [R12] Read-only; writes ignored, reads side-effect free
package ready_summary_pkg;

    // ===============================================================
    // Geometry
    localparam int          NUM_CHAN      = 4;
    localparam int          SUMMARY_WIDTH = 8;
    localparam int          TX_READY_LSB  = 0;
    localparam int          RX_READY_LSB  = 4;
    localparam logic [7:0]  SUMMARY_RESET = 8'h00;

    // ===============================================================
    // DMA signalling mode, as held in each channel's fifo_control_reg
    localparam logic        DMA_MODE_0    = 1'b0;
    localparam logic        DMA_MODE_1    = 1'b1;

    // ===============================================================
    // Timing, in receive-clock cycles
    localparam int          RX_IRQ_MAX_RCLK      = 1;
    localparam int          RX_READY_MAX_RCLK    = 1;
    localparam int          TX_START_MIN_RCLK    = 8;
    localparam int          TX_START_MAX_RCLK    = 24;
    localparam int          TX_READY_DROP_RCLK   = 8;
    localparam int          TX_START_DELAY_RCLK  = (TX_START_MIN_RCLK + TX_START_MAX_RCLK) / 2;
    localparam int          DELAY_CNT_WIDTH      = 5;
    localparam logic [4:0]  TX_START_LOAD        = 5'(TX_START_DELAY_RCLK);
    localparam logic [4:0]  DELAY_ZERO           = 5'h00;
    localparam logic [4:0]  DELAY_ONE            = 5'h01;

    // ===============================================================
    // Receive clock derived from ref_clk (40 MHz, 25 ns)
    localparam int          REF_CLK_NS           = 25;
    localparam int          RCLK_DIV_DEFAULT     = 2;
    localparam int          RCLK_CNT_WIDTH       = 8;

endpackage

// file: design/chan_ready.sv
// One channel's tx-ready, rx-ready, receive interrupt and transmit start delay.
// Assumes FIFO status and event pulses come from logic on ref_clk.
`timescale 1ns/100ps

module chan_ready (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic rclk_tick,
    // Channel configuration and FIFO state
    input  wire logic dma_mode,
    input  wire logic tx_fifo_empty,
    input  wire logic tx_fifo_full,
    input  wire logic rx_fifo_empty,
    input  wire logic rx_at_trigger,
    input  wire logic rx_timeout,
    // Serial engine events
    input  wire logic rx_stop_done,
    input  wire logic tx_start_bit,
    input  wire logic tx_irq_clear,
    input  wire logic rx_irq_ack,
    // Results
    output logic      tx_ready_reg,
    output logic      rx_ready_reg,
    output logic      rx_irq_reg,
    output logic      tx_go_reg
);

    logic [4:0] delay_reg;
    logic       pending_reg;
    wire  logic tx_ready_next;
    wire  logic rx_ready_next;
    wire  logic first_clear;
    wire  logic delay_done;

    // ===============================================================
    // Ready conditions
    assign tx_ready_next = (dma_mode == ready_summary_pkg::DMA_MODE_0) ?
                           tx_fifo_empty :                        // [R2]
                           !tx_fifo_full;                         // [R3]
    assign rx_ready_next = (dma_mode == ready_summary_pkg::DMA_MODE_0) ?
                           !rx_fifo_empty :                       // [R4]
                           (rx_at_trigger || rx_timeout);         // [R5]

    // Later clears while a start is pending do not restart the wait
    assign first_clear = tx_irq_clear && !pending_reg;
    assign delay_done  = pending_reg && rclk_tick &&
                         (delay_reg == ready_summary_pkg::DELAY_ONE);

    // ===============================================================
    // Ready flags: one ref_clk behind FIFO state, well inside one rclk
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_ready_reg <= 1'b0;
            rx_ready_reg <= 1'b0;
        end else begin
            // A start bit means the FIFO just gave up a word; drop at once
            tx_ready_reg <= tx_ready_next && !tx_start_bit;       // [R9]
            rx_ready_reg <= rx_ready_next;                        // [R8]
        end
    end

    // ===============================================================
    // Receive interrupt: set wins over acknowledge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_irq_reg <= 1'b0;
        end else if (rx_stop_done && rx_ready_next) begin
            rx_irq_reg <= 1'b1;                                   // [R6]
        end else if (rx_irq_ack) begin
            rx_irq_reg <= 1'b0;
        end
    end

    // ===============================================================
    // Transmit start delay counted in rclk ticks
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            delay_reg   <= ready_summary_pkg::DELAY_ZERO;
            pending_reg <= 1'b0;
            tx_go_reg   <= 1'b0;
        end else begin
            tx_go_reg <= delay_done;                              // [R7]
            if (first_clear) begin
                delay_reg   <= ready_summary_pkg::TX_START_LOAD;  // [R7]
                pending_reg <= 1'b1;
            end else if (delay_done) begin
                delay_reg   <= ready_summary_pkg::DELAY_ZERO;
                pending_reg <= 1'b0;
            end else if (pending_reg && rclk_tick) begin
                delay_reg   <= delay_reg - ready_summary_pkg::DELAY_ONE;
            end
        end
    end

endmodule

// file: design/fifo_ready_summary.sv
// Top of the four-channel FIFO-ready summary register and its timing.
// Assumes host pins are asynchronous; channel signals share ref_clk.
`timescale 1ns/100ps

module fifo_ready_summary #(
    parameter int RCLK_DIV = ready_summary_pkg::RCLK_DIV_DEFAULT
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Host pins
    input  wire logic       summary_status_select_n,
    input  wire logic       ior_n,
    input  wire logic       iow_n,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    // Per-channel configuration and FIFO state, bit 0 = channel A
    input  wire logic [3:0] dma_mode,
    input  wire logic [3:0] tx_fifo_empty,
    input  wire logic [3:0] tx_fifo_full,
    input  wire logic [3:0] rx_fifo_empty,
    input  wire logic [3:0] rx_at_trigger,
    input  wire logic [3:0] rx_timeout,
    // Per-channel serial engine events
    input  wire logic [3:0] rx_stop_done,
    input  wire logic [3:0] tx_start_bit,
    input  wire logic [3:0] tx_irq_clear,
    input  wire logic [3:0] rx_irq_ack,
    // Per-channel results
    output logic      [3:0] tx_ready,
    output logic      [3:0] rx_ready,
    output logic      [3:0] rx_irq,
    output logic      [3:0] tx_go
);

    // ===============================================================
    // Receive clock enable
    logic [ready_summary_pkg::RCLK_CNT_WIDTH-1:0] div_reg;
    logic                                         rclk_tick_reg;
    wire  logic                                   div_wrap;

    assign div_wrap = (div_reg == ready_summary_pkg::RCLK_CNT_WIDTH'(RCLK_DIV - 1));

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_reg       <= '0;
            rclk_tick_reg <= 1'b0;
        end else begin
            div_reg       <= div_wrap ? '0 : div_reg + ready_summary_pkg::RCLK_CNT_WIDTH'(1);
            rclk_tick_reg <= div_wrap;
        end
    end

    // ===============================================================
    // Host pin synchronisers
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    wire  logic sel_active;
    wire  logic read_active;
    wire  logic write_seen;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_meta_reg <= 3'h7;
            pin_sync_reg <= 3'h7;
        end else begin
            pin_meta_reg <= {iow_n, ior_n, summary_status_select_n};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign sel_active  = !pin_sync_reg[0];                        // [R10]
    assign read_active = sel_active && !pin_sync_reg[1];
    // Writes are decoded only to mask data_oe; data_in never reaches a flop
    assign write_seen  = sel_active && !pin_sync_reg[2];          // [R12]

    // ===============================================================
    // Channel cells
    logic [3:0] tx_ready_w;
    logic [3:0] rx_ready_w;

    for (genvar ch = 0; ch < ready_summary_pkg::NUM_CHAN; ch++) begin : g_chan
        chan_ready u_chan (
            .ref_clk       (ref_clk),
            .rst           (rst),
            .rclk_tick     (rclk_tick_reg),
            .dma_mode      (dma_mode[ch]),
            .tx_fifo_empty (tx_fifo_empty[ch]),
            .tx_fifo_full  (tx_fifo_full[ch]),
            .rx_fifo_empty (rx_fifo_empty[ch]),
            .rx_at_trigger (rx_at_trigger[ch]),
            .rx_timeout    (rx_timeout[ch]),
            .rx_stop_done  (rx_stop_done[ch]),
            .tx_start_bit  (tx_start_bit[ch]),
            .tx_irq_clear  (tx_irq_clear[ch]),
            .rx_irq_ack    (rx_irq_ack[ch]),
            .tx_ready_reg  (tx_ready_w[ch]),
            .rx_ready_reg  (rx_ready_w[ch]),
            .rx_irq_reg    (rx_irq[ch]),
            .tx_go_reg     (tx_go[ch])
        );
    end

    assign tx_ready = tx_ready_w;
    assign rx_ready = rx_ready_w;

    // ===============================================================
    // Summary register
    logic [7:0] fifo_ready_summary_reg;
    wire  logic [7:0] fifo_ready_summary_next;

    assign fifo_ready_summary_next[ready_summary_pkg::TX_READY_LSB +: 4] = tx_ready_w; // [R1]
    assign fifo_ready_summary_next[ready_summary_pkg::RX_READY_LSB +: 4] = rx_ready_w; // [R4]

    // Updated from channel state only; a host read or write never feeds back
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fifo_ready_summary_reg <= ready_summary_pkg::SUMMARY_RESET;     // [R11]
        end else begin
            fifo_ready_summary_reg <= fifo_ready_summary_next;             // [R12]
        end
    end

    // ===============================================================
    // Read data drive; disabled during any write so the bus is never fought
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_out <= ready_summary_pkg::SUMMARY_RESET;
            data_oe  <= 1'b0;
        end else begin
            data_out <= read_active ? fifo_ready_summary_reg : ready_summary_pkg::SUMMARY_RESET;
            data_oe  <= read_active && !write_seen;                        // [R10]
        end
    end

endmodule

// file: testbench/summary_props.sv
// Checker for the FIFO-ready summary block, bound to its top module.
// Assumes one transmit clear in flight per channel at a time.
`timescale 1ns/100ps

module summary_props #(
    parameter int RCLK_DIV = 2
) (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // Host pins
    input wire logic       summary_status_select_n,
    input wire logic       ior_n,
    input wire logic       iow_n,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    // Channel events and results
    input wire logic [3:0] rx_stop_done,
    input wire logic [3:0] tx_start_bit,
    input wire logic [3:0] tx_irq_clear,
    input wire logic [3:0] rx_irq_ack,
    input wire logic [3:0] tx_ready,
    input wire logic [3:0] rx_ready,
    input wire logic [3:0] rx_irq,
    input wire logic [3:0] tx_go
);
    localparam int GO_SPAN = 24 * RCLK_DIV - 7;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Host reads pass two synchronisers, so answers lag by 3 edges
    sequence rd_held;
        (!summary_status_select_n && !ior_n && iow_n && $stable({rx_ready, tx_ready}))[*4];
    endsequence
    sequence go_quiet;
        (!tx_go[0])[*8];
    endsequence
    summary_reset_a: assert property (disable iff (1'b0) rst |=> data_out == 8'h00 && !data_oe)
        else $error("summary not cleared by reset");
    // Summary register lags the ready pins by one edge and data_out by one more
    read_answer_a: assert property (rd_held |=> data_oe &&
        data_out == $past({rx_ready, tx_ready}, 2))
        else $error("read did not return the summary");
    read_release_a: assert property (ior_n[*4] |=> !data_oe)
        else $error("data bus still driven after read");
    write_mask_a: assert property ((!iow_n)[*4] |=> !data_oe)
        else $error("data bus driven during write");
    rx_irq_set_a: assert property (rx_stop_done[0] && rx_ready[0] |=> rx_irq[0])
        else $error("receive interrupt late after stop");
    rx_irq_hold_a: assert property (rx_irq[0] && !rx_irq_ack[0] |=> rx_irq[0])
        else $error("receive interrupt lost without ack");
    rx_irq_clear_a: assert property (rx_irq_ack[0] && !rx_stop_done[0] |=> !rx_irq[0])
        else $error("receive interrupt not cleared");
    tx_ready_drop_a: assert property (tx_start_bit[0] |=> !tx_ready[0])
        else $error("tx ready not dropped after start");
    tx_go_window_a: assert property (tx_irq_clear[0] |-> go_quiet ##[0:GO_SPAN] tx_go[0])
        else $error("transmit start outside its window");
    tx_go_pulse_a: assert property (tx_go[0] |=> !tx_go[0])
        else $error("transmit start longer than one cycle");
endmodule

bind fifo_ready_summary summary_props #(.RCLK_DIV(RCLK_DIV)) summary_props_inst (.*);

// file: testbench/host_model.sv
// Host processor model on the parallel CPU bus.
// Assumes pins move on falling edges of ref_clk.
`timescale 1ns/100ps

module host_model (
    // Clock
    input wire logic       ref_clk,
    // Bus pins toward the device
    output logic           summary_status_select_n,
    output logic           ior_n,
    output logic           iow_n,
    output logic     [7:0] data_in,
    // Read data from the device
    input wire logic [7:0] data_out,
    input wire logic       data_oe
);
    initial begin
        summary_status_select_n = 1'b1;
        ior_n = 1'b1;
        iow_n = 1'b1;
        data_in = 8'h5a;
    end
    // Select and strobe stay low until the device drives the bus or eight cycles pass
    task automatic read_reg(output logic [7:0] d, output bit ok);
        int n;
        ok = 1'b0;
        d = 8'h00;
        @(negedge ref_clk);
        summary_status_select_n = 1'b0;
        ior_n = 1'b0;
        for (n = 0; n < 8 && !ok; n++) begin
            @(negedge ref_clk);
            if (data_oe === 1'b1) begin
                ok = 1'b1;
                d = data_out;
            end
        end
        // Hold through the edge at which data_oe is sampled high
        if (ok) begin
            @(negedge ref_clk);
        end
        summary_status_select_n = 1'b1;
        ior_n = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask
    // Both strobes low together; the device must keep off the bus throughout
    task automatic clash_reg(output bit driven);
        driven = 1'b0;
        @(negedge ref_clk);
        summary_status_select_n = 1'b0;
        ior_n = 1'b0;
        iow_n = 1'b0;
        repeat (6) begin
            @(negedge ref_clk);
            if (data_oe !== 1'b0) begin
                driven = 1'b1;
            end
        end
        summary_status_select_n = 1'b1;
        ior_n = 1'b1;
        iow_n = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic write_reg(input logic [7:0] d);
        @(negedge ref_clk);
        summary_status_select_n = 1'b0;
        iow_n = 1'b0;
        data_in = d;
        repeat (5) @(negedge ref_clk);
        summary_status_select_n = 1'b1;
        iow_n = 1'b1;
        data_in = ~d; // Released bus shows no stale value
        repeat (4) @(negedge ref_clk);
    endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the FIFO-ready summary block.
// Assumes RCLK_DIV of 1, so receive-clock counts equal ref_clk cycles.
`timescale 1ns/100ps

module tb_top;
    typedef struct packed {
        logic [3:0] mode, te, tf, re, rt, ro;
        logic [7:0] sum;
    } row_s;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       summary_status_select_n, ior_n, iow_n, data_oe;
    logic [7:0] data_in, data_out;
    logic [3:0] dma_mode = 4'h0, tx_fifo_empty = 4'h0, tx_fifo_full = 4'h0;
    logic [3:0] rx_fifo_empty = 4'hf, rx_at_trigger = 4'h0, rx_timeout = 4'h0;
    logic [3:0] rx_stop_done = 4'h0, tx_start_bit = 4'h0, tx_irq_clear = 4'h0;
    logic [3:0] rx_irq_ack = 4'h0, tx_ready, rx_ready, rx_irq, tx_go;
    int         miscompares = 0;
    int         num_checks = 0;
    row_s       rows [4] = '{'{4'h0, 4'ha, 4'h0, 4'h6, 4'h0, 4'h0, 8'h9a},
                             '{4'hf, 4'h0, 4'h5, 4'hf, 4'h3, 4'h4, 8'h7a},
                             '{4'h5, 4'h3, 4'he, 4'h8, 4'h1, 4'h4, 8'h73},
                             '{4'ha, 4'hc, 4'hf, 4'h0, 4'h8, 4'h2, 8'hf4}};

    fifo_ready_summary #(.RCLK_DIV(1)) fifo_ready_summary_inst (.ref_clk, .rst,
        .summary_status_select_n, .ior_n, .iow_n, .data_in, .data_out, .data_oe,
        .dma_mode, .tx_fifo_empty, .tx_fifo_full, .rx_fifo_empty, .rx_at_trigger,
        .rx_timeout, .rx_stop_done, .tx_start_bit, .tx_irq_clear, .rx_irq_ack,
        .tx_ready, .rx_ready, .rx_irq, .tx_go);
    host_model host_model_inst (.ref_clk, .summary_status_select_n, .ior_n, .iow_n,
        .data_in, .data_out, .data_oe);

    always #12.5 ref_clk = ~ref_clk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic read_check(input logic [7:0] exp, input string what);
        logic [7:0] d;
        bit         ok;
        host_model_inst.read_reg(d, ok);
        check({7'h0, ok}, 8'h01, what);
        check(d, exp, what);
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog: tests need under two hundred cycles
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end

    initial begin
        int i;
        int n;
        bit bad;
        step(5);
        rst = 1'b0;
        check(data_out, 8'h00, "reset data");
        check({7'h0, data_oe}, 8'h00, "reset oe");
        read_check(8'h00, "reset summary");
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            {dma_mode, tx_fifo_empty, tx_fifo_full, rx_fifo_empty, rx_at_trigger, rx_timeout}
                = rows[i][31:8];
            step(3);
            check({rx_ready, tx_ready}, rows[i].sum, "ready pins");
            read_check(rows[i].sum, "summary row");
        end
        $display("test table done");
        host_model_inst.write_reg(8'hff);
        read_check(8'hf4, "after write");
        read_check(8'hf4, "second read");
        host_model_inst.clash_reg(bad);
        check({7'h0, bad}, 8'h00, "read during write");
        $display("test write done");
        dma_mode = 4'h0;
        tx_fifo_empty = 4'hf;
        rx_fifo_empty = 4'he;
        step(3);
        tx_start_bit = 4'h1;
        step(1);
        tx_start_bit = 4'h0;
        check({4'h0, tx_ready}, 8'h0e, "tx drop");
        rx_stop_done = 4'h1;
        step(1);
        rx_stop_done = 4'h0;
        check({4'h0, rx_irq}, 8'h01, "rx irq set");
        rx_irq_ack = 4'h1;
        step(1);
        rx_irq_ack = 4'h0;
        check({4'h0, rx_irq}, 8'h00, "rx irq ack");
        rx_fifo_empty = 4'hf;
        step(3);
        rx_stop_done = 4'h1;
        step(1);
        rx_stop_done = 4'h0;
        check({4'h0, rx_irq}, 8'h00, "rx irq empty");
        rx_fifo_empty = 4'he;
        step(3);
        rx_stop_done = 4'h1;
        rx_irq_ack = 4'h1;
        step(1);
        rx_stop_done = 4'h0;
        rx_irq_ack = 4'h0;
        check({4'h0, rx_irq}, 8'h01, "rx irq set wins");
        $display("test events done");
        tx_irq_clear = 4'h1;
        step(1);
        tx_irq_clear = 4'h0;
        for (n = 1; n < 40 && tx_go[0] !== 1'b1; n++) begin
            step(1);
        end
        check({7'h0, n >= 8 && n <= 24}, 8'h01, "tx start delay");
        step(1);
        check({7'h0, tx_go[0]}, 8'h00, "tx start pulse");
        $display("test transmit start done");
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        check({rx_ready, tx_ready}, 8'h00, "mid-run reset ready");
        check({rx_irq, tx_go}, 8'h00, "mid-run reset events");
        check({7'h0, data_oe}, 8'h00, "mid-run reset oe");
        read_check(8'h1f, "read after reset");
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
